// file: ebwt_pkg.sv
// ebwt_pkg: constants for the external bus wait timing core
// assumes one clock (pclk) and a single active-low asynchronous reset
package ebwt_pkg;
  // -------------------------------------------------------------------
  // register map (byte addresses, one aligned 32-bit word each)
  // -------------------------------------------------------------------
  localparam logic [7:0]  EBWT_OFS_CTRL     = 8'h00;
  localparam logic [7:0]  EBWT_OFS_PWAIT    = 8'h04;
  localparam logic [7:0]  EBWT_OFS_DWAIT    = 8'h08;
  localparam logic [7:0]  EBWT_OFS_REQ      = 8'h0c;
  localparam logic [7:0]  EBWT_OFS_WDATA    = 8'h10;
  localparam logic [7:0]  EBWT_OFS_STATUS   = 8'h14;
  localparam logic [7:0]  EBWT_OFS_RDATA    = 8'h18;
  localparam logic [7:0]  EBWT_OFS_STATES   = 8'h1c;
  // -------------------------------------------------------------------
  // field positions and reset values
  // -------------------------------------------------------------------
  localparam int          EBWT_CTRL_AUTO3   = 0;
  localparam int          EBWT_REQ_WRITE    = 20;
  localparam int          EBWT_REQ_DATA     = 21;
  localparam int          EBWT_REQ_LEN_LSB  = 24;
  localparam logic [1:0]  EBWT_PWAIT_RST    = 2'h3;
  localparam logic [2:0]  EBWT_DWAIT_RST    = 3'h7;
  // -------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------
  localparam int          EBWT_MIN_STATES   = 2;
  localparam int          EBWT_MAX_STATES   = 48;
  localparam logic [1:0]  EBWT_AUTO_SHORT   = 2'h2;
  localparam logic [1:0]  EBWT_AUTO_LONG    = 2'h3;
  localparam logic [19:0] EBWT_INT_TOP      = 20'h1ffff;
  localparam int          EBWT_CLK_MHZ      = 100;
  localparam int          EBWT_STATE_NS     = 1000 / EBWT_CLK_MHZ;
  typedef enum logic [1:0] {EBWT_IDLE, EBWT_ADDR, EBWT_HOLD, EBWT_DONE} ebwt_state_t;
endpackage : ebwt_pkg

// file: ebwt_acc_if.sv
`timescale 1ns/1ps
// ebwt_acc_if: access request and completion between core and sequencer
// assumes both ends sit on the same pclk
interface ebwt_acc_if;
  logic        start;
  logic        is_data;
  logic        is_write;
  logic [19:0] addr;
  logic [7:0]  wdata;
  logic [4:0]  total;
  logic        busy;
  logic        done;
  logic [7:0]  rdata;
  modport core (output start, is_data, is_write, addr, wdata, total, input busy, done, rdata);
  modport seq  (input start, is_data, is_write, addr, wdata, total, output busy, done, rdata);
endinterface : ebwt_acc_if

// file: ebwt_state_cnt.sv
`timescale 1ns/1ps
// ebwt_state_cnt: counts instruction states, one per clock pulse
// assumes start pulses one cycle while idle with len in range
module ebwt_state_cnt
  import ebwt_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       start,
  input  wire logic [5:0] len,
  output logic      [5:0] state_idx,
  output logic            cycle_end,
  output logic            running
);
  logic [5:0] cnt_r;
  logic       run_r;
  // --------------------------------------------------------------
  // state counter: each pclk pulse is exactly one state
  // --------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 6'h00;
      run_r <= 1'b0;
    end else if (start && !run_r) begin
      cnt_r <= 6'h01;
      run_r <= 1'b1;
    end else if (run_r) begin
      if (cnt_r >= len) begin
        run_r <= 1'b0;
        cnt_r <= 6'h00;
      end else begin
        cnt_r <= cnt_r + 6'h01;
      end
    end
  end
  assign state_idx = cnt_r;
  assign running   = run_r;
  assign cycle_end = run_r && (cnt_r >= len);

  // cycle length clamped to the documented window
  a_len_range: assert property (@(posedge pclk) disable iff (!presetn)
    (start && !run_r) |-> (len >= 6'(EBWT_MIN_STATES)) && (len <= 6'(EBWT_MAX_STATES)))
    else $error("instruction cycle length out of range");
  a_state_step: assert property (@(posedge pclk) disable iff (!presetn)
    (run_r && !cycle_end) |=> (cnt_r == $past(cnt_r) + 6'h01))
    else $error("state counter skipped a pulse");
endmodule : ebwt_state_cnt

// file: ebwt_seq.sv
`timescale 1ns/1ps
// ebwt_seq: drives one external access for the requested state count
// assumes total >= 1 and start only while not busy
module ebwt_seq
  import ebwt_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        bus_type_strap,
  input  wire logic [7:0]  ext_data_in,
  output logic      [7:0]  port_addr_lo,
  output logic      [7:0]  port_addr_mid,
  output logic      [3:0]  port_addr_hi,
  output logic      [7:0]  port_data_out,
  output logic             port_data_oe,
  output logic             ale,
  output logic             prog_read_strobe_n,
  output logic             read_strobe_n,
  output logic             write_strobe_n,
  ebwt_acc_if.seq          acc
);
  ebwt_state_t st_r;
  logic [4:0]  left_r;
  logic [7:0]  rd_r;
  logic        kind_data_r;
  logic        kind_wr_r;
  logic [7:0]  kind_wdata_r;
  // --------------------------------------------------------------
  // access state machine; outputs frozen while waits count down
  // --------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r               <= EBWT_IDLE;
      left_r             <= 5'h00;
      rd_r               <= 8'h00;
      kind_data_r        <= 1'b0;
      kind_wr_r          <= 1'b0;
      kind_wdata_r       <= 8'h00;
      port_addr_lo       <= 8'h00;
      port_addr_mid      <= 8'h00;
      port_addr_hi       <= 4'h0;
      port_data_out      <= 8'h00;
      port_data_oe       <= 1'b0;
      ale                <= 1'b0;
      prog_read_strobe_n <= 1'b1;
      read_strobe_n      <= 1'b1;
      write_strobe_n     <= 1'b1;
    end else begin
      case (st_r)
        EBWT_IDLE: begin
          if (acc.start) begin
            left_r        <= acc.total;
            // the request lines move on once accepted, so keep the kind here
            kind_data_r   <= acc.is_data;
            kind_wr_r     <= acc.is_write;
            kind_wdata_r  <= acc.wdata;
            port_addr_mid <= acc.addr[15:8];
            port_addr_hi  <= acc.addr[19:16];
            if (bus_type_strap) begin
              // separate bus: address on its own port, strobe at once
              port_addr_lo       <= acc.addr[7:0];
              prog_read_strobe_n <= acc.is_data;
              read_strobe_n      <= !(acc.is_data && !acc.is_write);
              write_strobe_n     <= !(acc.is_data && acc.is_write);
              port_data_out      <= acc.wdata;
              port_data_oe       <= acc.is_data && acc.is_write;
              st_r               <= EBWT_HOLD;
            end else begin
              // multiplexed: address phase with latch enable first
              port_data_out <= acc.addr[7:0];
              port_data_oe  <= 1'b1;
              ale           <= 1'b1;
              st_r          <= EBWT_ADDR;
            end
          end
        end
        EBWT_ADDR: begin
          ale                <= 1'b0;
          port_data_out      <= kind_wdata_r;
          port_data_oe       <= kind_data_r && kind_wr_r;
          prog_read_strobe_n <= kind_data_r;
          read_strobe_n      <= !(kind_data_r && !kind_wr_r);
          write_strobe_n     <= !(kind_data_r && kind_wr_r);
          st_r               <= EBWT_HOLD;
        end
        EBWT_HOLD: begin
          // one state per remaining count; nothing on the pins moves
          if (left_r <= 5'h01) begin
            rd_r               <= ext_data_in;
            prog_read_strobe_n <= 1'b1;
            read_strobe_n      <= 1'b1;
            write_strobe_n     <= 1'b1;
            port_data_oe       <= 1'b0;
            st_r               <= EBWT_DONE;
          end else begin
            left_r <= left_r - 5'h01;
          end
        end
        default: st_r <= EBWT_IDLE;
      endcase
    end
  end
  assign acc.busy  = (st_r != EBWT_IDLE);
  assign acc.done  = (st_r == EBWT_DONE);
  assign acc.rdata = rd_r;

  a_hold_steady: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r == EBWT_HOLD && left_r > 5'h01) |=> $stable({port_addr_lo, port_addr_mid, prog_read_strobe_n,
                                                       read_strobe_n, write_strobe_n}))
    else $error("bus outputs moved during a wait state");
endmodule : ebwt_seq

// file: ebwt_core.sv
`timescale 1ns/1ps
// ebwt_core: external bus wait timing core, apb register front end
// assumes an apb master on pclk and straps stable while running
//
// Functional notes
// - one main clock pulse is one state
// - instruction cycle spans 2 to 48 states
// - prefetch one instruction byte during execution
// - program fetch adds 0 to 3 waits
// - data byte access adds 2 or 3
// - data access adds 0 to 7 more
// - strap low: all code fetched externally
// - bus strap high separate, low multiplexed
// - strap high: below 20000h internal
// - separate fetch drives address ports, program read strobe
module ebwt_core
  import ebwt_pkg::*;
(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                ext_prog_select_n,
  input  wire logic                bus_type_strap,
  input  wire logic [7:0]          ext_data_in,
  input  wire logic [7:0]          int_rom_data,
  output logic      [19:0]         int_rom_addr,
  output logic      [7:0]          port_addr_lo,
  output logic      [7:0]          port_addr_mid,
  output logic      [3:0]          port_addr_hi,
  output logic      [7:0]          port_data_out,
  output logic                     port_data_oe,
  output logic                     ale,
  output logic                     prog_read_strobe_n,
  output logic                     read_strobe_n,
  output logic                     write_strobe_n
);
  import ebwt_pkg::*;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic        auto3_r;
  logic [1:0]  prog_wait_count;
  logic [2:0]  data_wait_count;
  logic [19:0] pc_r;
  logic [5:0]  len_r;
  logic        req_data_r;
  logic        req_wr_r;
  logic [19:0] req_addr_r;
  logic [7:0]  wdata_r;
  logic        go_r;
  logic [7:0]  rdata_r;
  logic [7:0]  pf_byte_r;
  logic        pf_valid_r;
  logic        pf_pend_r;
  logic        dat_pend_r;
  logic        ext_path_r;
  logic [7:0]  states_r;
  logic        cur_data_r;

  ebwt_acc_if acc ();

  logic [5:0] state_idx;
  logic       cycle_end;
  logic       running;

  // decode of fetch location, used by both prefetch and status
  function automatic logic fetch_is_ext(input logic sel_n, input logic [19:0] a);
    fetch_is_ext = !sel_n || (a > EBWT_INT_TOP);
  endfunction : fetch_is_ext

  // ----------------------------------------------------------------
  // apb slave: zero wait states, unmapped reads zero with error
  // ----------------------------------------------------------------
  wire apb_acc  = psel && penable;
  wire apb_wr   = apb_acc && pwrite;
  wire req_hit  = apb_wr && (paddr == EBWT_OFS_REQ) && !running;
  assign pready = 1'b1;

  always_comb begin
    pslverr = 1'b0;
    prdata  = 32'h0000_0000;
    if (paddr == EBWT_OFS_CTRL) begin
      prdata = {31'h0, auto3_r};
    end else if (paddr == EBWT_OFS_PWAIT) begin
      prdata = {30'h0, prog_wait_count};
    end else if (paddr == EBWT_OFS_DWAIT) begin
      prdata = {29'h0, data_wait_count};
    end else if (paddr == EBWT_OFS_REQ) begin
      prdata = {2'h0, len_r, 2'h0, req_data_r, req_wr_r, pc_r};
    end else if (paddr == EBWT_OFS_WDATA) begin
      prdata = {24'h0, wdata_r};
    end else if (paddr == EBWT_OFS_STATUS) begin
      prdata = {24'h0, 2'h0, ext_path_r, pf_valid_r, pf_pend_r, dat_pend_r, acc.busy, running};
    end else if (paddr == EBWT_OFS_RDATA) begin
      prdata = {16'h0, pf_byte_r, rdata_r};
    end else if (paddr == EBWT_OFS_STATES) begin
      prdata = {24'h0, states_r};
    end else begin
      pslverr = apb_acc;
    end
  end

  // configuration registers written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto3_r         <= 1'b0;
      prog_wait_count <= EBWT_PWAIT_RST;
      data_wait_count <= EBWT_DWAIT_RST;
      wdata_r         <= 8'h00;
    end else if (apb_wr) begin
      if (paddr == EBWT_OFS_CTRL) begin
        auto3_r <= pwdata[EBWT_CTRL_AUTO3];
      end else if (paddr == EBWT_OFS_PWAIT) begin
        prog_wait_count <= pwdata[1:0];
      end else if (paddr == EBWT_OFS_DWAIT) begin
        data_wait_count <= pwdata[2:0];
      end else if (paddr == EBWT_OFS_WDATA) begin
        wdata_r <= pwdata[7:0];
      end
    end
  end

  // instruction request: length clamped to 2..48 states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_r       <= 20'h00000;
      len_r      <= 6'(EBWT_MIN_STATES);
      req_data_r <= 1'b0;
      req_wr_r   <= 1'b0;
      req_addr_r <= 20'h00000;
      go_r       <= 1'b0;
    end else begin
      go_r <= req_hit;
      if (req_hit) begin
        req_addr_r <= pwdata[19:0];
        req_wr_r   <= pwdata[EBWT_REQ_WRITE];
        req_data_r <= pwdata[EBWT_REQ_DATA];
        if (pwdata[29:24] < 6'(EBWT_MIN_STATES)) begin
          len_r <= 6'(EBWT_MIN_STATES);
        end else if (pwdata[29:24] > 6'(EBWT_MAX_STATES)) begin
          len_r <= 6'(EBWT_MAX_STATES);
        end else begin
          len_r <= pwdata[29:24];
        end
      end else if (cycle_end) begin
        pc_r <= pc_r + 20'h00001;
      end
    end
  end

  ebwt_state_cnt u_cnt (
    .pclk      (pclk),
    .presetn   (presetn),
    .start     (go_r),
    .len       (len_r),
    .state_idx (state_idx),
    .cycle_end (cycle_end),
    .running   (running)
  );

  // ----------------------------------------------------------------
  // access scheduling: data access first, then prefetch of next byte
  // ----------------------------------------------------------------
  wire [19:0] next_pc = pc_r + 20'h00001;
  wire        pf_ext  = fetch_is_ext(ext_prog_select_n, next_pc);
  wire        issue_d = dat_pend_r && !acc.busy;
  wire        issue_p = pf_pend_r && !dat_pend_r && !acc.busy && pf_ext;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pf_pend_r  <= 1'b0;
      dat_pend_r <= 1'b0;
      pf_valid_r <= 1'b0;
      pf_byte_r  <= 8'h00;
      rdata_r    <= 8'h00;
      ext_path_r <= 1'b0;
      states_r   <= 8'h00;
      cur_data_r <= 1'b0;
      int_rom_addr <= 20'h00000;
    end else begin
      if (issue_d) begin
        dat_pend_r <= 1'b0;
      end
      if (pf_pend_r && !dat_pend_r && !acc.busy && !pf_ext) begin
        // internal program memory: one state, no wait insertion
        int_rom_addr <= next_pc;
        pf_pend_r    <= 1'b0;
        pf_valid_r   <= 1'b1;
      end
      if (pf_valid_r && !pf_ext && int_rom_addr == next_pc) begin
        pf_byte_r <= int_rom_data;
      end
      if (issue_p) begin
        pf_pend_r <= 1'b0;
      end
      // dat_pend_r drops as the access goes out, so remember its kind
      if (acc.start) begin
        cur_data_r <= dat_pend_r;
      end
      if (acc.done) begin
        if (cur_data_r) begin
          rdata_r <= acc.rdata;
        end else begin
          pf_byte_r  <= acc.rdata;
          pf_valid_r <= 1'b1;
        end
      end
      // a new cycle's request is placed last so it wins over a clear
      if (go_r) begin
        pf_pend_r  <= 1'b1;
        pf_valid_r <= 1'b0;
        dat_pend_r <= req_data_r;
        ext_path_r <= fetch_is_ext(ext_prog_select_n, pc_r + 20'h00001);
        states_r   <= 8'h00;
      end else if (acc.busy) begin
        states_r <= states_r + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // access request to the sequencer with its total state count
  // ----------------------------------------------------------------
  wire [1:0] auto_n = auto3_r ? EBWT_AUTO_LONG : EBWT_AUTO_SHORT;
  assign acc.start    = issue_d || issue_p;
  assign acc.is_data  = dat_pend_r;
  assign acc.is_write = req_wr_r;
  assign acc.addr     = dat_pend_r ? req_addr_r : next_pc;
  assign acc.wdata    = wdata_r;
  assign acc.total    = dat_pend_r ? 5'({3'h0, auto_n} + {2'h0, data_wait_count})
                                   : 5'({3'h0, prog_wait_count} + 5'h01);

  ebwt_seq u_seq (
    .pclk               (pclk),
    .presetn            (presetn),
    .bus_type_strap     (bus_type_strap),
    .ext_data_in        (ext_data_in),
    .port_addr_lo       (port_addr_lo),
    .port_addr_mid      (port_addr_mid),
    .port_addr_hi       (port_addr_hi),
    .port_data_out      (port_data_out),
    .port_data_oe       (port_data_oe),
    .ale                (ale),
    .prog_read_strobe_n (prog_read_strobe_n),
    .read_strobe_n      (read_strobe_n),
    .write_strobe_n     (write_strobe_n),
    .acc                (acc)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_prog_start;
    acc.start && !acc.is_data;
  endsequence
  sequence s_data_start;
    acc.start && acc.is_data;
  endsequence
  a_prog_waits: assert property (@(posedge pclk) disable iff (!presetn)
    s_prog_start |-> acc.total == 5'({3'h0, prog_wait_count} + 5'h01))
    else $error("program fetch wait count wrong");
  a_data_auto: assert property (@(posedge pclk) disable iff (!presetn)
    s_data_start |-> acc.total >= 5'h02 && acc.total <= 5'h0a)
    else $error("data access state count out of range");
  a_data_waits: assert property (@(posedge pclk) disable iff (!presetn)
    s_data_start |-> acc.total - 5'({3'h0, auto_n}) == 5'({2'h0, data_wait_count}))
    else $error("data wait cycles not added");
  a_ext_all: assert property (@(posedge pclk) disable iff (!presetn)
    (!ext_prog_select_n && pf_pend_r && !dat_pend_r && !acc.busy) |-> acc.start)
    else $error("fetch not external with select low");
  a_int_region: assert property (@(posedge pclk) disable iff (!presetn)
    (ext_prog_select_n && next_pc <= EBWT_INT_TOP) |-> !issue_p)
    else $error("internal region fetched externally");
  a_sep_strobe: assert property (@(posedge pclk) disable iff (!presetn)
    (s_prog_start and (bus_type_strap && !acc.busy)) |=> !prog_read_strobe_n && !ale)
    else $error("separate fetch strobe missing");
  a_mux_latch: assert property (@(posedge pclk) disable iff (!presetn)
    (acc.start && !bus_type_strap && !acc.busy) |=> ale ##1 !ale)
    else $error("multiplexed address latch missing");
  a_prefetch: assert property (@(posedge pclk) disable iff (!presetn)
    go_r |=> pf_pend_r)
    else $error("prefetch not requested");
endmodule : ebwt_core

// file: ebwt_ext_mem.sv
`timescale 1ns/1ps
// ebwt_ext_mem: external program and data memory facing the bus ports
// assumes the core's strobes are active low and ale marks the low address
module ebwt_ext_mem (
  input  wire logic        pclk,
  input  wire logic        bus_type_strap,
  input  wire logic [7:0]  port_addr_lo,
  input  wire logic [7:0]  port_addr_mid,
  input  wire logic [3:0]  port_addr_hi,
  input  wire logic [7:0]  port_data_out,
  input  wire logic        port_data_oe,
  input  wire logic        ale,
  input  wire logic        prog_read_strobe_n,
  input  wire logic        read_strobe_n,
  input  wire logic        write_strobe_n,
  output logic      [7:0]  ext_data_in,
  output logic      [19:0] p_addr,
  output logic      [19:0] d_addr,
  output logic      [7:0]  p_len,
  output logic      [7:0]  d_len,
  output logic      [7:0]  wdat,
  output logic      [7:0]  n_prog,
  output logic             steady_err
);
  logic [7:0]  lat_lo_r = 8'h00;
  logic [7:0]  len_r    = 8'h00;
  logic [7:0]  fill_r   = 8'h00;
  logic [19:0] held_r   = 20'h00000;
  logic        prog_r   = 1'b0;
  logic        act;
  logic [19:0] cur;
  initial n_prog = 8'h00;
  initial steady_err = 1'b0;
  // memory contents are a fixed scramble of the address
  function automatic logic [7:0] mem_byte(input logic [19:0] a);
    return a[7:0] ^ a[15:8] ^ {4'h0, a[19:16]} ^ 8'h5a;
  endfunction : mem_byte
  // low byte comes from the latch on a multiplexed bus
  assign cur = {port_addr_hi, port_addr_mid, bus_type_strap ? port_addr_lo : lat_lo_r};
  assign act = !prog_read_strobe_n || !read_strobe_n || !write_strobe_n;
  // released data line shows fill_r, which stays at 00h since negating zero gives zero
  assign ext_data_in = (!prog_read_strobe_n || !read_strobe_n) ? mem_byte(cur) : fill_r;
  // measure each strobe and check the address stays put meanwhile
  always @(posedge pclk) begin
    fill_r <= ~fill_r + 8'h01;
    if (ale === 1'b1) lat_lo_r <= port_data_out;
    if (act === 1'b1) begin
      len_r  <= len_r + 8'h01;
      held_r <= cur;
      prog_r <= !prog_read_strobe_n;
      if (len_r != 8'h00 && held_r !== cur) steady_err <= 1'b1;
      // write data only counts while the core drives the data port
      if (!write_strobe_n && port_data_oe === 1'b1) wdat <= port_data_out;
    end else if (len_r != 8'h00) begin
      len_r <= 8'h00;
      if (prog_r) begin
        p_len  <= len_r;
        p_addr <= held_r;
        n_prog <= n_prog + 8'h01;
      end else begin
        d_len  <= len_r;
        d_addr <= held_r;
      end
    end
  end
endmodule : ebwt_ext_mem

// file: tb.sv
`timescale 1ns/1ps
// tb: self-checking bench for ebwt_core over apb
// assumes ebwt_ext_mem stands in for the external memory
module tb;
  import ebwt_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, oe, ale, psn, rsn, wsn, serr;
  logic        sel_n = 1'b0, bus = 1'b1;
  logic [7:0]  din, rom_d, lo, mid, dout, p_len, d_len, wdat, n_prog;
  logic [3:0]  hi;
  logic [19:0] rom_a, p_addr, d_addr;
  int          n_mismatch = 0;
  int          checks_done = 0;
  always #5 pclk = ~pclk;
  // internal code byte follows its address
  assign rom_d = rom_a[7:0] + 8'h11;
  ebwt_core uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_prog_select_n(sel_n), .bus_type_strap(bus), .ext_data_in(din), .int_rom_data(rom_d),
    .int_rom_addr(rom_a), .port_addr_lo(lo), .port_addr_mid(mid), .port_addr_hi(hi),
    .port_data_out(dout), .port_data_oe(oe), .ale(ale), .prog_read_strobe_n(psn),
    .read_strobe_n(rsn), .write_strobe_n(wsn));
  ebwt_ext_mem mem (.pclk(pclk), .bus_type_strap(bus), .port_addr_lo(lo), .port_addr_mid(mid),
    .port_addr_hi(hi), .port_data_out(dout), .port_data_oe(oe), .ale(ale), .prog_read_strobe_n(psn),
    .read_strobe_n(rsn), .write_strobe_n(wsn), .ext_data_in(din), .p_addr(p_addr),
    .d_addr(d_addr), .p_len(p_len), .d_len(d_len), .wdat(wdat), .n_prog(n_prog), .steady_err(serr));
  // -------------------------------------------------------------------
  // shared tasks
  // -------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one apb transfer; waits an edge first so back-to-back calls never reassign in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) chk("pready", pready, 1'b1);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic e;
    apb(1'b0, a, 32'h0, d, e);
  endtask : rd
  // poll status until neither running nor bus busy, bounded
  task automatic wait_idle();
    logic [31:0] s;
    int n;
    n = 0;
    do begin
      rd(EBWT_OFS_STATUS, s);
      n++;
    end while (s[1:0] !== 2'h0 && n < 200);
    if (n >= 200) chk("idle", s[1:0], 2'h0);
  endtask : wait_idle
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  // -------------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] r;
    logic e;
    chk("strobes", {psn, rsn, wsn}, 3'h7);
    rd(EBWT_OFS_PWAIT, r);
    chk("pwait reset", r[1:0], EBWT_PWAIT_RST);
    rd(EBWT_OFS_DWAIT, r);
    chk("dwait reset", r[2:0], EBWT_DWAIT_RST);
    apb(1'b0, 8'h20, 32'h0, r, e);
    chk("unmapped err", {31'h0, e}, 32'h1);
    chk("unmapped rdata", r, 32'h0);
  endtask : t_reset
  // one short cycle; the prefetch of pc+1 goes out or stays inside
  task automatic t_prog(input logic en, input logic b, input logic [1:0] pw);
    logic [31:0] pc, r;
    logic [7:0] np;
    sel_n <= en;
    bus <= b;
    wr(EBWT_OFS_PWAIT, {30'h0, pw});
    rd(EBWT_OFS_REQ, pc);
    np = n_prog;
    wr(EBWT_OFS_REQ, 32'h0200_0000);
    wait_idle();
    rd(EBWT_OFS_RDATA, r);
    if (!en) begin
      chk("prog len", p_len, pw + 8'h01);
      chk("prog addr", p_addr, pc[19:0] + 20'h1);
      chk("prog byte", r[15:8], mem.mem_byte(pc[19:0] + 20'h1));
    end else begin
      chk("no ext fetch", n_prog, np);
      chk("int byte", r[15:8], pc[7:0] + 8'h12);
    end
  endtask : t_prog
  task automatic t_data(input logic b, input logic a3, input logic [2:0] dw, input logic w,
                        input logic [19:0] a, input logic [7:0] wd);
    logic [31:0] r;
    bus <= b;
    wr(EBWT_OFS_CTRL, {31'h0, a3});
    wr(EBWT_OFS_DWAIT, {29'h0, dw});
    wr(EBWT_OFS_WDATA, {24'h0, wd});
    wr(EBWT_OFS_REQ, {2'b00, 6'd48, 2'b00, 1'b1, w, a});
    wait_idle();
    rd(EBWT_OFS_RDATA, r);
    chk("data len", d_len, (a3 ? 8'h03 : 8'h02) + dw);
    chk("data addr", d_addr, a);
    if (w) chk("wdata", wdat, wd);
    else chk("rdata", r[7:0], mem.mem_byte(a));
  endtask : t_data
  // a second request while a long cycle runs must not disturb it
  task automatic t_busy();
    logic [31:0] s;
    wr(EBWT_OFS_REQ, 32'h3020_1234);
    wr(EBWT_OFS_REQ, 32'h3020_5678);
    rd(EBWT_OFS_STATUS, s);
    chk("running", s[0], 1'b1);
    wait_idle();
    chk("busy addr", d_addr, 20'h01234);
  endtask : t_busy
  // -------------------------------------------------------------------
  // main sequence and watchdog
  // -------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    for (int i = 0; i < 4; i++) t_prog(1'b0, i[0], i[1:0]);
    t_prog(1'b1, 1'b1, 2'h0);
    sel_n <= 1'b0;
    for (int i = 0; i < 4; i++) t_data(i[0], i[1], i[1] ? 3'h7 : 3'h0, i[0] ^ i[1],
                                       20'h2a5c3 + 20'(i * 257), 8'h3c + 8'(i));
    t_busy();
    chk("steady", serr, 1'b0);
    end_sim();
  end
  initial begin
    #300000;
    n_mismatch++;
    $display("CHECK FAILED watchdog expected done seen hang");
    end_sim();
  end
endmodule : tb
